// ### common/tw_if.sv
// Two-wire link between the bus master end and the register access slave end.
// Resolves the open-drain wires from the enables; the bench drives link_clk.
`default_nettype none
interface tw_if;
  logic link_clk;
  logic m_scl_o, m_scl_oe, m_sda_o, m_sda_oe;
  logic s_sda_o, s_sda_oe;
  logic scl, sda;

  // Released lines are pulled high.
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport dev (input link_clk, input scl, input sda, output s_sda_o, output s_sda_oe);
  modport mst (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface
`default_nettype wire

// ### common/tw_pkg.sv
// Types shared by both ends of the two-wire register access link.
// Assumes tw_regs.svh is on the include path.
`default_nettype none
package tw_pkg;
  `include "tw_regs.svh"

  typedef enum logic [2:0] {
    TW_D_IDLE, TW_D_ADDR, TW_D_ADDR_END, TW_D_ACK, TW_D_RX, TW_D_RX_END, TW_D_TX, TW_D_TX_ACK
  } tw_dev_st_t;

  typedef enum logic [1:0] {TW_OP_START, TW_OP_WBYTE, TW_OP_RBYTE, TW_OP_STOP} tw_op_t;
  typedef enum logic [1:0] {TW_K_WRITE, TW_K_RAND_READ, TW_K_CUR_READ} tw_kind_t;
  typedef enum logic {TW_M_IDLE, TW_M_RUN} tw_mst_st_t;

  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    logic sel1, sel2, en1, en2, tg1, tg2, tg3;
    tw_dev_st_t st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [1:0] idx;
    logic [15:0] ptr;
    logic [7:0] prog;
    logic [7:0] rd;
    logic sda_oe;
    logic req_tog, req_wr;
    logic [15:0] req_addr;
    logic [7:0] req_wdata;
  } tw_dev_link_t;

  typedef struct packed {
    logic t1, t2, t3;
    logic req_valid, req_write;
    logic [15:0] req_addr;
    logic [7:0] req_wdata;
    logic wait_rsp, rsp_tog;
    logic [7:0] rsp_data;
  } tw_dev_sys_t;

  typedef struct packed {
    tw_op_t op;
    logic [7:0] data;
  } tw_plan_t;

  typedef struct packed {
    tw_mst_st_t st;
    tw_op_t op;
    tw_kind_t kind;
    logic [2:0] step;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic nack, done, scl_low, sda_low, sda1, sda2;
  } tw_mst_t;
endpackage
`default_nettype wire

// ### common/tw_regs.svh
// Constants of the two-wire register access link: addresses, fields, timing.
// Assumes inclusion by bare name from the package and the design files.
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

// Seven-bit slave identities (write bytes 0x20 and 0x30).
`define TW_ID_DEFAULT 7'h10
`define TW_ID_ALT 7'h18
// Programmable identity register, held as the write address byte.
`define TW_PROG_ID_ADDR 16'h31fc
`define TW_PROG_ID_RST 8'h20
// Direction bit of the address byte.
`define TW_DIR_BIT 0
`define TW_DIR_WRITE 1'b0
`define TW_DIR_READ 1'b1
// Timing: system clock period and least serial clock period, in ns.
`define TW_CLK_PERIOD_NS 40
`define TW_SCL_PERIOD_NS 4000
`define TW_QUARTER_CYCLES ((`TW_SCL_PERIOD_NS + 4 * `TW_CLK_PERIOD_NS - 1) / (4 * `TW_CLK_PERIOD_NS))

`endif

// ### dv/tw_link_checker.sv
// Assertions on the two-wire link, sampled on the slave's link clock.
// Assumes the bench instantiates it beside the interface with all pins by name.
`default_nettype none
module tw_link_checker (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Pin values and enables
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  // Resolved wires
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, first_q;
  logic [3:0] bitc_q;

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (rst);

  // ****
  // Frame tracking
  // ****
  // Bit count restarts at every start so that the ninth clock of each byte is known.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      first_q <= 1'b0;
      bitc_q <= 4'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bitc_q <= 4'h0;
        first_q <= 1'b1;
      end else if (scl && !scl_q) begin
        bitc_q <= (bitc_q == 4'h9) ? 4'h1 : bitc_q + 4'h1;
        if (bitc_q == 4'h8) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  sequence s_start;
    scl && scl_q && sda_q && !sda;
  endsequence
  sequence s_stop;
    scl && scl_q && !sda_q && sda;
  endsequence
  sequence s_ninth_rise;
    scl && !scl_q && bitc_q == 4'h8;
  endsequence
  sequence s_low_setup;
    !scl [*8];
  endsequence

  a_slave_pulls_low: assert property (s_sda_oe |-> !s_sda_o)
    else $error("slave data pin driven high");
  a_clock_pulls_low: assert property (m_scl_oe |-> !m_scl_o)
    else $error("clock pin driven high");
  a_master_pulls_low: assert property (m_sda_oe |-> !m_sda_o)
    else $error("master data pin driven high");
  a_master_data_steady: assert property (scl && scl_q && $changed(m_sda_oe) |-> (m_sda_oe ? (sda_q && !sda) : (!sda_q && sda)))
    else $error("master data changed while clock high outside start or stop");
  a_slave_hold_high: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("slave data changed while clock high");
  a_slave_change_setup: assert property ($changed(s_sda_oe) |-> s_low_setup)
    else $error("slave data changed too close to clock rise");
  a_start_released: assert property (s_start |-> !s_sda_oe)
    else $error("slave drives data at start");
  a_stop_released: assert property (s_stop |-> !s_sda_oe [*8])
    else $error("slave drives data after stop");
  a_ninth_released: assert property (s_ninth_rise |-> !m_sda_oe)
    else $error("master drives data on ninth clock");
  a_addr_quiet: assert property (first_q && scl && (scl_q || bitc_q != 4'h8) |-> !s_sda_oe)
    else $error("slave drives data during address byte");
endmodule
`default_nettype wire

// ### dv/two_wire_register_access_slave_bench.sv
// Bench joining the master end to the register access slave end over the link.
// Assumes the package, interface, design modules and checker are compiled first.
`default_nettype none
`include "tw_regs.svh"
module two_wire_register_access_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tw_pkg::*;

  // Short bits keep the run brief; 8 leaves room for the read answer.
  localparam int QC = 8;
  typedef struct packed {logic nack; logic rd; logic [7:0] data;} tw_done_exp_t;
  typedef struct packed {logic wr; logic [15:0] addr; logic [7:0] data;} tw_req_exp_t;
  logic clk, rst, cmd_valid, cmd_ready, done, nack, alt_en, alt_sel, req_valid, req_write, rsp_valid, cur_match;
  logic [15:0] req_addr, cmd_addr, ptr;
  logic [7:0] req_wdata, rsp_rdata, rdata, cmd_wdata, wire_sh;
  logic [6:0] cmd_id;
  tw_kind_t cmd_kind;
  tw_done_exp_t done_q[$];
  tw_req_exp_t req_q[$];
  int n_mismatch, n_tests, cycles, nbits;
  tw_if bus_if();

  tw_mst #(.QUARTER_CYCLES(QC)) i_tw_mst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_kind(cmd_kind), .cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .done(done), .nack(nack),
    .rdata(rdata), .bus(bus_if.mst));
  tw_dev i_tw_dev (.clk(clk), .rst(rst), .alt_address_select_enable(alt_en), .alt_address_select_input(alt_sel),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus(bus_if.dev));
  tw_link_checker i_tw_link_checker (.link_clk(bus_if.link_clk), .rst(rst), .m_scl_o(bus_if.m_scl_o),
    .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe), .s_sda_o(bus_if.s_sda_o),
    .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    bus_if.link_clk = 1'b0;
    #3;
    forever #6 bus_if.link_clk = ~bus_if.link_clk;
  end

  // ****
  // Checking
  // ****
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h5a;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The user side answers every read in the same cycle as the request.
  always @(posedge clk) begin
    #1;
    rsp_valid = (req_valid === 1'b1 && req_write === 1'b0);
    if (rsp_valid) begin
      rsp_rdata = mem_val(req_addr);
    end
  end

  always @(posedge clk) begin
    tw_done_exp_t e;
    tw_req_exp_t r;
    cycles++;
    if (cycles > 80000) begin
      n_mismatch++;
      wrap_up();
    end
    if (done === 1'b1) begin
      e = done_q.pop_front();
      check({31'h0, nack}, {31'h0, e.nack});
      if (e.rd) check({24'h0, rdata}, {24'h0, e.data});
    end
    if (req_valid === 1'b1) begin
      r = req_q.pop_front();
      check({7'h0, req_write, req_addr, req_write ? req_wdata : 8'h00}, {7'h0, r.wr, r.addr, r.data});
    end
  end

  // The first byte after each start carries the identity, then the ninth bit is the answer.
  // Data may fall in the same step as the clock; judge the clock once it has settled.
  always @(negedge bus_if.sda) begin
    #1;
    if (bus_if.scl === 1'b1) nbits = 0;
  end
  always @(posedge bus_if.scl) begin
    nbits++;
    if (nbits <= 8) wire_sh = {wire_sh[6:0], bus_if.sda};
    if (nbits == 8) check({25'h0, wire_sh[7:1]}, {25'h0, cmd_id});
    if (nbits == 9) check({31'h0, bus_if.sda}, {31'h0, !cur_match});
  end

  // ****
  // Stimulus
  // ****
  task automatic run(input tw_kind_t k, input logic [6:0] id, input logic [15:0] a, input logic [7:0] w,
                     input logic ok);
    tw_done_exp_t e;
    tw_req_exp_t r;
    logic [15:0] at;
    at = (k == TW_K_CUR_READ) ? ptr : a;
    e = '{nack: !ok, rd: ok && k != TW_K_WRITE, data: mem_val(at)};
    done_q.push_back(e);
    if (ok) begin
      r = '{wr: k == TW_K_WRITE, addr: at, data: (k == TW_K_WRITE) ? w : 8'h00};
      req_q.push_back(r);
      ptr = at + 16'h0001;
    end
    cur_match = ok;
    @(posedge clk);
    #1;
    check({31'h0, cmd_ready}, 32'h1);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_id = id;
    cmd_addr = a;
    cmd_wdata = w;
    @(posedge clk);
    #1;
    check({31'h0, cmd_ready}, 32'h0);
    cmd_valid = 1'b0;
    do begin
      @(posedge clk);
      #1;
    end while (done !== 1'b1);
  endtask

  initial begin
    tw_kind_t k;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = TW_K_WRITE;
    cmd_id = `TW_ID_DEFAULT;
    cmd_addr = 16'h0000;
    cmd_wdata = 8'h00;
    alt_en = 1'b0;
    alt_sel = 1'b0;
    rsp_valid = 1'b0;
    rsp_rdata = 8'h00;
    ptr = 16'h0000;
    cur_match = 1'b0;
    wire_sh = 8'h00;
    nbits = 99;
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    void'($urandom(28409));
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    run(TW_K_WRITE, `TW_ID_DEFAULT, 16'h1234, 8'ha5, 1'b1);
    run(TW_K_CUR_READ, `TW_ID_DEFAULT, 16'h0000, 8'h00, 1'b1);
    run(TW_K_RAND_READ, `TW_ID_DEFAULT, 16'h12ff, 8'h00, 1'b1);
    run(TW_K_CUR_READ, `TW_ID_DEFAULT, 16'h0000, 8'h00, 1'b1);
    run(TW_K_WRITE, `TW_ID_ALT, 16'h0040, 8'h11, 1'b0);
    run(TW_K_CUR_READ, 7'h11, 16'h0000, 8'h00, 1'b0);
    run(TW_K_CUR_READ, `TW_ID_DEFAULT, 16'h0000, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++) begin
      alt_en = i[1];
      alt_sel = i[0];
      run(TW_K_WRITE, `TW_ID_ALT, 16'(16'h2000 + i), 8'h30, i == 3);
      run(TW_K_CUR_READ, `TW_ID_DEFAULT, 16'h0000, 8'h00, i != 3);
    end
    alt_en = 1'b0;
    alt_sel = 1'b0;
    run(TW_K_WRITE, `TW_ID_DEFAULT, `TW_PROG_ID_ADDR, 8'h44, 1'b1);
    run(TW_K_WRITE, `TW_ID_DEFAULT, 16'h0100, 8'h01, 1'b0);
    run(TW_K_RAND_READ, 7'h22, 16'h0100, 8'h00, 1'b1);
    run(TW_K_WRITE, 7'h22, `TW_PROG_ID_ADDR, `TW_PROG_ID_RST, 1'b1);
    for (int i = 0; i < 8; i++) begin
      k = tw_kind_t'($urandom_range(2, 0));
      run(k, `TW_ID_DEFAULT, {4'h0, 12'($urandom())}, 8'($urandom()), 1'b1);
    end
    repeat (20) @(posedge clk);
    check({31'h0, done_q.size() == 0 && req_q.size() == 0}, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire

// ### rtl/tw_dev.sv
// Register access slave end of the two-wire link.
// Assumes link_clk runs fast enough to oversample the serial clock and that
// the user answers each read request well within half a serial clock period.
// Notes on behaviour
// - address byte: identity high, direction low
// - direction bit zero writes, one reads
// - default identity answers 0x20 and 0x21
// - enabled select input switches to 0x30/0x31
// - identity programmable through its own register
// - later bytes carry address, data or readback
// - ninth clock: sender releases, receiver pulls low
// - data changes only while clock is low
// - released line on ninth clock means no-acknowledge
// - acknowledge address only on identity match
// - register address sent high byte first
// - one data byte acknowledged, then stop/restart (the code also acknowledges and writes any further bytes)
// - read: address write, restart, read, acknowledge
// - register pointer increments after every data byte
// - stop driving data after master no-acknowledge
// - random read starts with address-only write
// - single read ends with no-acknowledge, stop
// - current read uses the present pointer
// - serial clock is only ever an input
// - start is data falling while clock high
// - stop is data rising while clock high
// - bytes shift most significant bit first
`default_nettype none
`include "tw_regs.svh"
module tw_dev
  import tw_pkg::*;
(
  // System side
  input wire logic clk,
  input wire logic rst,
  // Identity select pins
  input wire logic alt_address_select_enable,
  input wire logic alt_address_select_input,
  // Register requests
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [7:0] req_wdata,
  // Read answers
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_rdata,
  // Link
  tw_if.dev bus
);
  import tw_pkg::*;

  // ****************************************
  // Link domain
  // ****************************************
  tw_dev_link_t lq, ln;
  tw_dev_sys_t sq, sn;
  logic start, stop, rise, fall;
  logic [6:0] id;
  logic [7:0] dat;

  // Events are judged on the second and third stages only.
  assign start = lq.scl2 & lq.scl3 & lq.sda3 & ~lq.sda2;
  assign stop = lq.scl2 & lq.scl3 & ~lq.sda3 & lq.sda2;
  assign rise = lq.scl2 & ~lq.scl3;
  assign fall = ~lq.scl2 & lq.scl3;
  // The select pin wins over the programmed identity.
  assign id = (lq.en2 & lq.sel2) ? `TW_ID_ALT : lq.prog[7:1];
  // The identity register is answered locally; the user answer is ignored.
  assign dat = (lq.req_addr == `TW_PROG_ID_ADDR) ? lq.prog : lq.rd;

  always_comb begin
    ln = lq;
    ln.scl1 = bus.scl;
    ln.scl2 = lq.scl1;
    ln.scl3 = lq.scl2;
    ln.sda1 = bus.sda;
    ln.sda2 = lq.sda1;
    ln.sda3 = lq.sda2;
    ln.sel1 = alt_address_select_input;
    ln.sel2 = lq.sel1;
    ln.en1 = alt_address_select_enable;
    ln.en2 = lq.en1;
    ln.tg1 = sq.rsp_tog;
    ln.tg2 = lq.tg1;
    ln.tg3 = lq.tg2;
    // Read data is stable in the system domain once its toggle arrives.
    if (lq.tg2 != lq.tg3) begin
      ln.rd = sq.rsp_data;
    end
    if (start) begin
      ln.st = TW_D_ADDR;
      ln.cnt = 3'h0;
      ln.sda_oe = 1'b0;
    end else if (stop) begin
      ln.st = TW_D_IDLE;
      ln.sda_oe = 1'b0;
    end else begin
      case (lq.st)
        TW_D_ADDR: begin
          if (rise) begin
            ln.sh = {lq.sh[6:0], lq.sda2};
            ln.cnt = lq.cnt + 3'h1;
            if (lq.cnt == 3'h7) begin
              ln.st = TW_D_ADDR_END;
            end
          end
        end
        TW_D_ADDR_END: begin
          if (fall) begin
            if (lq.sh[7:1] == id) begin
              ln.sda_oe = 1'b1;
              ln.rw = lq.sh[`TW_DIR_BIT];
              ln.idx = 2'h0;
              ln.st = TW_D_ACK;
              if (lq.sh[`TW_DIR_BIT] == `TW_DIR_READ) begin
                // The pointer is used as it stands.
                ln.req_tog = ~lq.req_tog;
                ln.req_wr = 1'b0;
                ln.req_addr = lq.ptr;
              end
            end else begin
              ln.st = TW_D_IDLE;
            end
          end
        end
        TW_D_ACK: begin
          if (fall) begin
            ln.sda_oe = 1'b0;
            ln.cnt = 3'h0;
            if (lq.rw == `TW_DIR_READ) begin
              ln.sh = dat;
              ln.sda_oe = ~dat[7];
              ln.st = TW_D_TX;
            end else begin
              ln.st = TW_D_RX;
            end
          end
        end
        TW_D_RX: begin
          if (rise) begin
            ln.sh = {lq.sh[6:0], lq.sda2};
            ln.cnt = lq.cnt + 3'h1;
            if (lq.cnt == 3'h7) begin
              ln.st = TW_D_RX_END;
            end
          end
        end
        TW_D_RX_END: begin
          if (fall) begin
            ln.sda_oe = 1'b1;
            ln.st = TW_D_ACK;
            case (lq.idx)
              2'h0: begin
                ln.ptr[15:8] = lq.sh;
                ln.idx = 2'h1;
              end
              2'h1: begin
                // An address-only write ends here and just loads the pointer.
                ln.ptr[7:0] = lq.sh;
                ln.idx = 2'h2;
              end
              default: begin
                ln.req_tog = ~lq.req_tog;
                ln.req_wr = 1'b1;
                ln.req_addr = lq.ptr;
                ln.req_wdata = lq.sh;
                if (lq.ptr == `TW_PROG_ID_ADDR) begin
                  ln.prog = lq.sh;
                end
                ln.ptr = lq.ptr + 16'h0001;
              end
            endcase
          end
        end
        TW_D_TX: begin
          if (fall) begin
            if (lq.cnt == 3'h7) begin
              ln.sda_oe = 1'b0;
              ln.ptr = lq.ptr + 16'h0001;
              ln.st = TW_D_TX_ACK;
            end else begin
              ln.sh = {lq.sh[6:0], 1'b0};
              ln.sda_oe = ~lq.sh[6];
              ln.cnt = lq.cnt + 3'h1;
            end
          end
        end
        TW_D_TX_ACK: begin
          if (rise) begin
            if (!lq.sda2) begin
              // Acknowledged: fetch the next byte before the next fall.
              ln.st = TW_D_ACK;
              ln.req_tog = ~lq.req_tog;
              ln.req_wr = 1'b0;
              ln.req_addr = lq.ptr;
            end else begin
              ln.st = TW_D_IDLE;
            end
          end
        end
        default: begin
          ln.st = TW_D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge bus.link_clk or posedge rst) begin
    if (rst) begin
      lq <= '0;
      lq.prog <= `TW_PROG_ID_RST;
    end else begin
      lq <= ln;
    end
  end

  // The device only ever pulls the data line low.
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = lq.sda_oe;

  // ****************************************
  // System domain
  // ****************************************
  // Request fields are held by the link side from the toggle until the next
  // one, at least a byte time later, so they are safe to sample here.
  always_comb begin
    sn = sq;
    sn.t1 = lq.req_tog;
    sn.t2 = sq.t1;
    sn.t3 = sq.t2;
    sn.req_valid = 1'b0;
    if (sq.t2 != sq.t3) begin
      sn.req_valid = 1'b1;
      sn.req_write = lq.req_wr;
      sn.req_addr = lq.req_addr;
      sn.req_wdata = lq.req_wdata;
      sn.wait_rsp = ~lq.req_wr;
    end else if (sq.wait_rsp && rsp_valid) begin
      sn.rsp_data = rsp_rdata;
      sn.rsp_tog = ~sq.rsp_tog;
      sn.wait_rsp = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sq <= '0;
    end else begin
      sq <= sn;
    end
  end

  assign req_valid = sq.req_valid;
  assign req_write = sq.req_write;
  assign req_addr = sq.req_addr;
  assign req_wdata = sq.req_wdata;
endmodule
`default_nettype wire

// ### rtl/tw_mst.sv
// Bus master end of the two-wire link: single write, random and current read.
// Assumes the slave never stretches the clock; the clock is made by a divider.
`default_nettype none
`include "tw_regs.svh"
module tw_mst
  import tw_pkg::*;
#(
  parameter int QUARTER_CYCLES = `TW_QUARTER_CYCLES
) (
  // System side
  input wire logic clk,
  input wire logic rst,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire tw_pkg::tw_kind_t cmd_kind,
  input wire logic [6:0] cmd_id,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  // Result
  output logic done,
  output logic nack,
  output logic [7:0] rdata,
  // Link
  tw_if.mst bus
);
  import tw_pkg::*;

  // Below four quarters the far end's two-stage lag no longer fits in a clock phase.
  if (QUARTER_CYCLES < 4 || QUARTER_CYCLES > 65535) begin : g_chk
    $error("QUARTER_CYCLES out of range");
  end

  localparam logic [15:0] DIV_LOAD = 16'(QUARTER_CYCLES - 1);

  tw_mst_t q, n;

  // Byte plan of each transfer kind, step by step.
  function automatic tw_plan_t plan(input tw_kind_t k, input logic [2:0] s, input logic [6:0] i,
                                    input logic [15:0] a, input logic [7:0] w);
    tw_plan_t p;
    p.op = TW_OP_STOP;
    p.data = {i, `TW_DIR_WRITE};
    if (k == TW_K_CUR_READ) begin
      case (s)
        3'h0: p.op = TW_OP_START;
        3'h1: begin
          p.op = TW_OP_WBYTE;
          p.data = {i, `TW_DIR_READ};
        end
        3'h2: p.op = TW_OP_RBYTE;
        default: p.op = TW_OP_STOP;
      endcase
    end else begin
      case (s)
        3'h0: p.op = TW_OP_START;
        3'h1: p.op = TW_OP_WBYTE;
        3'h2: begin
          p.op = TW_OP_WBYTE;
          p.data = a[15:8];
        end
        3'h3: begin
          p.op = TW_OP_WBYTE;
          p.data = a[7:0];
        end
        3'h4: begin
          p.op = (k == TW_K_WRITE) ? TW_OP_WBYTE : TW_OP_START;
          p.data = w;
        end
        3'h5: begin
          p.op = (k == TW_K_WRITE) ? TW_OP_STOP : TW_OP_WBYTE;
          p.data = {i, `TW_DIR_READ};
        end
        3'h6: p.op = (k == TW_K_WRITE) ? TW_OP_STOP : TW_OP_RBYTE;
        default: p.op = TW_OP_STOP;
      endcase
    end
    return p;
  endfunction

  tw_plan_t nxt;
  assign nxt = plan(q.kind, q.step + 3'h1, cmd_id, q.addr, q.wdata);
  assign cmd_ready = (q.st == TW_M_IDLE);

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.sda1 = bus.sda;
    n.sda2 = q.sda1;
    if (q.st == TW_M_IDLE) begin
      n.scl_low = 1'b0;
      n.sda_low = 1'b0;
      if (cmd_valid) begin
        n.st = TW_M_RUN;
        n.op = TW_OP_START;
        n.kind = cmd_kind;
        n.addr = cmd_addr;
        n.wdata = cmd_wdata;
        n.step = 3'h0;
        n.q = 2'h0;
        n.div = 16'h0000;
        n.nack = 1'b0;
      end
    end else if (q.div != 16'h0000) begin
      n.div = q.div - 16'h0001;
    end else begin
      n.div = DIV_LOAD;
      n.q = q.q + 2'h1;
      case (q.op)
        TW_OP_START: begin
          // Release data while clock is low, then pull it low under a high clock.
          case (q.q)
            2'h0: begin
              n.scl_low = 1'b1;
              n.sda_low = 1'b0;
            end
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b1;
            default: ;
          endcase
        end
        TW_OP_STOP: begin
          case (q.q)
            2'h0: begin
              n.scl_low = 1'b1;
              n.sda_low = 1'b1;
            end
            2'h1: n.scl_low = 1'b0;
            2'h2: n.sda_low = 1'b0;
            default: begin
              n.st = TW_M_IDLE;
              n.done = 1'b1;
            end
          endcase
        end
        default: begin
          case (q.q)
            2'h0: begin
              // A read byte is always the last: its ninth bit is left released.
              n.scl_low = 1'b1;
              n.sda_low = (q.bitn < 4'h8) && (q.op == TW_OP_WBYTE) && !q.sh[7];
            end
            2'h2: n.scl_low = 1'b0;
            2'h3: begin
              if (q.bitn < 4'h8) begin
                n.sh = {q.sh[6:0], q.sda2};
                n.bitn = q.bitn + 4'h1;
              end else if (q.op == TW_OP_RBYTE) begin
                n.rdata = q.sh;
              end else if (q.sda2) begin
                n.nack = 1'b1;
              end
            end
            default: ;
          endcase
        end
      endcase
      // Element boundary: move to the next step of the plan.
      if (q.q == 2'h3 && q.op != TW_OP_STOP && (q.op == TW_OP_START || q.bitn == 4'h8)) begin
        n.step = q.step + 3'h1;
        n.bitn = 4'h0;
        n.sh = nxt.data;
        n.op = nxt.op;
        if (q.op == TW_OP_WBYTE && q.sda2) begin
          n.op = TW_OP_STOP;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Open-drain drive of both lines.
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = q.scl_low;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = q.sda_low;
  assign done = q.done;
  assign nack = q.nack;
  assign rdata = q.rdata;
endmodule
`default_nettype wire
